// ===== hw/rlar_pkg.sv
// shared constants and types for reference-loss and auto-restart protection
package rlar_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned REF_WIN_MS = 400;
  localparam longint unsigned REF_WIN_CYC = CLK_HZ / 1000 * REF_WIN_MS;
  localparam longint unsigned CHECK_MS = 5;
  localparam longint unsigned CHECK_CYC = CLK_HZ / 1000 * CHECK_MS;
  localparam longint unsigned FAULT_FREE_MIN = 10;
  localparam longint unsigned FAULT_FREE_CYC = CLK_HZ * 60 * FAULT_FREE_MIN;
  localparam int TMR_W = 40;

  // ****************************************************************
  // reference handling
  // ****************************************************************
  localparam int REF_W = 16;
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  localparam logic [31:0] LOSS_DROP_PCT = 32'h0000_005a;
  localparam logic [7:0] RUN_PCT_RST = 8'h50;

  // ****************************************************************
  // restart settings and output function codes
  // ****************************************************************
  localparam logic [3:0] LIMIT_MAX = 4'ha;
  localparam logic [3:0] LIMIT_RST = 4'h0;
  localparam logic [7:0] MF_REF_LOST = 8'h0c;
  localparam logic [7:0] MF_AUTO_RESTART = 8'h1e;

  // fault bits 0..13: overcurrent, ground, fuse_blown, overvoltage,
  // undervoltage, main_voltage, output_phase, resistor_overheat,
  // brake_transistor, motor_overload, drive_overload, motor_overheat,
  // overtorque_a, overtorque_b; bits 14..15 are other faults
  localparam int NUM_FAULTS = 16;
  localparam logic [NUM_FAULTS-1:0] RESTART_MASK = 16'h3fff;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_HELD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MFO_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 8'h04;
  localparam int CFG_RESP_BIT = 0;
  localparam int CFG_RELAY_BIT = 1;
  localparam int CFG_LIMIT_LSB = 8;
  localparam int CFG_PCT_LSB = 16;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_LOST_BIT = 2;
  localparam int STS_USED_LSB = 4;
  localparam int STS_RELAY_BIT = 8;
  localparam int STS_LOCK_BIT = 9;

  // gray coded along run -> wait -> restart -> lock; restart -> run flips both bits
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_RESTART = 2'b11,
    ST_LOCK = 2'b10
  } rlar_state_type;

endpackage

// ===== hw/rlar_ref_loss.sv
// analog frequency reference loss detector
`timescale 1ns/1ps
`default_nettype none
module rlar_ref_loss
  import rlar_pkg::*;
#(
  parameter longint unsigned WIN_CYC = REF_WIN_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [REF_W-1:0] ref_in,
  output logic lost_q,
  output logic [REF_W-1:0] held_q
);

  localparam logic [TMR_W-1:0] WIN_LAST = TMR_W'(WIN_CYC - 1);

  typedef struct packed {
    logic [TMR_W-1:0] win_cnt;
    logic [REF_W-1:0] base;
    logic [REF_W-1:0] held;
    logic lost;
  } rlar_det_type;

  rlar_det_type q, d;
  logic [31:0] cur_x;
  logic [31:0] base_x;
  logic [31:0] held_x;
  logic drop_hit;
  logic recover;

  // ****************************************************************
  // detection
  // ****************************************************************
  // base is refreshed once per window; a drop that straddles a window
  // edge may be seen late, traded for a single compare per cycle
  always_comb begin
    d = q;
    cur_x = {16'h0000, ref_in} * PCT_FULL;
    base_x = {16'h0000, q.base} * (PCT_FULL - LOSS_DROP_PCT);
    held_x = {16'h0000, q.held} * (PCT_FULL - LOSS_DROP_PCT);
    drop_hit = (q.base != '0) && (cur_x <= base_x);
    recover = cur_x > held_x;
    if (!q.lost) begin
      if (drop_hit) begin
        d.lost = 1'b1;
        d.held = q.base;
      end else if (q.win_cnt == WIN_LAST) begin
        d.win_cnt = '0;
        d.base = ref_in;
      end else begin
        d.win_cnt = q.win_cnt + 1'b1;
      end
    end else if (recover) begin
      d.lost = 1'b0;
      d.base = ref_in;
      d.win_cnt = '0;
    end
  end

  // state register; no detection before the first window closes
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lost_q = q.lost;
  assign held_q = q.held;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_loss_detect: assert property (
    (!q.lost && drop_hit) |=> (q.lost && q.held == $past(q.base)))
    else $error("reference drop not flagged as loss");

endmodule // rlar_ref_loss
`default_nettype wire

// ===== hw/rlar_protect.sv
// reference-loss response and auto-restart sequencer with register port
`timescale 1ns/1ps
`default_nettype none
module rlar_protect
  import rlar_pkg::*;
#(
  parameter int NUM_MFO = 5,
  parameter longint unsigned WIN_CYC = REF_WIN_CYC,
  parameter longint unsigned CHK_CYC = CHECK_CYC,
  parameter longint unsigned FF_CYC = FAULT_FREE_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [REF_W-1:0] ref_in,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic fault_reset_pin,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output logic [REF_W-1:0] freq_ref_out_q,
  output logic drive_stop_q,
  output logic restart_req_q,
  output logic fault_relay_q,
  output logic [NUM_MFO-1:0] mfo_q
);

  localparam logic [TMR_W-1:0] CHK_LAST = TMR_W'(CHK_CYC - 1);
  localparam logic [TMR_W-1:0] FF_LAST = TMR_W'(FF_CYC - 1);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic rst_s3;
    rlar_state_type st;
    logic [3:0] used;
    logic attempted;
    logic [TMR_W-1:0] chk_cnt;
    logic [TMR_W-1:0] ff_cnt;
    logic resp_sel;
    logic relay_sel;
    logic [3:0] limit;
    logic [7:0] run_pct;
    logic [NUM_MFO-1:0][7:0] mfo_sel;
    logic [31:0] rdata;
    logic [REF_W-1:0] freq_out;
    logic stop;
    logic restart;
    logic relay;
    logic [NUM_MFO-1:0] mfo;
  } rlar_ctl_type;

  rlar_ctl_type q, d;
  logic lost;
  logic [REF_W-1:0] held;
  logic [NUM_MFO-1:0] mf_hit;
  logic restarting;
  logic any_fault;
  logic nr_fault;
  logic freset;
  logic [3:0] used_inc;
  logic [3:0] used_next;
  logic [3:0] wr_limit;
  logic [31:0] scaled_x;
  logic [REF_W-1:0] scaled;

  // ****************************************************************
  // reference loss detector
  // ****************************************************************
  rlar_ref_loss #(
    .WIN_CYC(WIN_CYC)
  ) u_ref_loss (
    .mclk(mclk),
    .reset(reset),
    .ref_in(ref_in),
    .lost_q(lost),
    .held_q(held)
  );

  // ****************************************************************
  // multi-function outputs
  // ****************************************************************
  assign restarting = (q.st == ST_WAIT) || (q.st == ST_RESTART);

  // each output compares its own function code
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MFO; gi++) begin : g_mfo
      assign mf_hit[gi] = ((q.mfo_sel[gi] == MF_REF_LOST) && lost) ||
                          ((q.mfo_sel[gi] == MF_AUTO_RESTART) && restarting);
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    // fault reset terminal: two flops, then edge detect on the second
    d.rst_s1 = fault_reset_pin;
    d.rst_s2 = q.rst_s1;
    d.rst_s3 = q.rst_s2;
    freset = q.rst_s2 && !q.rst_s3;
    any_fault = |fault_in;
    nr_fault = |(fault_in & ~RESTART_MASK);
    used_inc = q.used + 4'h1;
    used_next = q.attempted ? used_inc : q.used;
    d.restart = 1'b0;

    case (q.st)
      ST_RUN: begin
        if (any_fault) begin
          d.ff_cnt = '0;
          d.used = used_next;
          if (nr_fault || (used_next >= q.limit)) begin
            d.st = ST_LOCK;
          end else begin
            d.st = ST_WAIT;
            d.chk_cnt = '0;
          end
        end else if (q.attempted) begin
          if (q.ff_cnt == FF_LAST) begin
            d.used = '0;
            d.attempted = 1'b0;
            d.ff_cnt = '0;
          end else begin
            d.ff_cnt = q.ff_cnt + 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (nr_fault) begin
          d.st = ST_LOCK;
        end else if (q.chk_cnt == CHK_LAST) begin
          d.chk_cnt = '0;
          if (!any_fault) begin
            d.st = ST_RESTART;
            d.restart = 1'b1;
          end
        end else begin
          d.chk_cnt = q.chk_cnt + 1'b1;
        end
      end
      ST_RESTART: begin
        d.st = ST_RUN;
        d.attempted = 1'b1;
        d.ff_cnt = '0;
      end
      ST_LOCK: begin
        // reset only once faults are gone
        if (freset && !any_fault) begin
          d.st = ST_RUN;
          d.used = '0;
          d.attempted = 1'b0;
        end
      end
      default: begin
        d.st = ST_LOCK;
      end
    endcase

    // register writes; an out-of-range limit is clamped, not refused
    wr_limit = reg_wdata[CFG_LIMIT_LSB +: 4];
    if (reg_wr) begin
      if (reg_addr == REG_CONFIG) begin
        d.resp_sel = reg_wdata[CFG_RESP_BIT];
        d.relay_sel = reg_wdata[CFG_RELAY_BIT];
        d.limit = (wr_limit > LIMIT_MAX) ? LIMIT_MAX : wr_limit;
        d.run_pct = reg_wdata[CFG_PCT_LSB +: 8];
      end
      for (int i = 0; i < NUM_MFO; i++) begin
        if (reg_addr == REG_MFO_BASE + ADDR_W'(i) * WORD_BYTES) begin
          d.mfo_sel[i] = reg_wdata[7:0];
        end
      end
    end

    // read data valid the cycle after the strobe only
    d.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == REG_CONFIG) begin
        d.rdata[CFG_RESP_BIT] = q.resp_sel;
        d.rdata[CFG_RELAY_BIT] = q.relay_sel;
        d.rdata[CFG_LIMIT_LSB +: 4] = q.limit;
        d.rdata[CFG_PCT_LSB +: 8] = q.run_pct;
      end else if (reg_addr == REG_STATUS) begin
        d.rdata[STS_STATE_LSB +: 2] = q.st;
        d.rdata[STS_LOST_BIT] = lost;
        d.rdata[STS_USED_LSB +: 4] = q.used;
        d.rdata[STS_RELAY_BIT] = q.relay;
        d.rdata[STS_LOCK_BIT] = (q.st == ST_LOCK);
      end else if (reg_addr == REG_HELD) begin
        d.rdata[REF_W-1:0] = held;
      end
      for (int i = 0; i < NUM_MFO; i++) begin
        if (reg_addr == REG_MFO_BASE + ADDR_W'(i) * WORD_BYTES) begin
          d.rdata[7:0] = q.mfo_sel[i];
        end
      end
    end

    scaled_x = ({16'h0000, held} * {24'h00_0000, q.run_pct}) / PCT_FULL;
    scaled = scaled_x[REF_W-1:0];
    if (lost) begin
      d.freq_out = q.resp_sel ? scaled : '0;
    end else begin
      d.freq_out = ref_in;
    end
    // stop on loss with response zero
    d.stop = (q.st == ST_WAIT) || (q.st == ST_LOCK) || (lost && !q.resp_sel);
    d.relay = (q.st == ST_LOCK) || (q.relay_sel && restarting);
    d.mfo = mf_hit;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // power-up reset clears count
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
      q.st <= ST_RUN;
      q.limit <= LIMIT_RST;
      q.run_pct <= RUN_PCT_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_q = q.rdata;
  assign freq_ref_out_q = q.freq_out;
  assign drive_stop_q = q.stop;
  assign restart_req_q = q.restart;
  assign fault_relay_q = q.relay;
  assign mfo_q = q.mfo;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_run_scaled: assert property (
    (lost && q.resp_sel) |=> (freq_ref_out_q == $past(scaled)))
    else $error("continued frequency is not the scaled held reference");

  a_mfo_lost: assert property (
    (q.mfo_sel[0] == MF_REF_LOST && lost) |=> mfo_q[0])
    else $error("reference lost output not asserted");

  a_stop_loss: assert property (
    (lost && !q.resp_sel) |=> (drive_stop_q && freq_ref_out_q == '0))
    else $error("drive not stopped on reference loss");

  a_limit_range: assert property (
    q.limit <= LIMIT_MAX)
    else $error("restart limit beyond range");

  a_other_lock: assert property (
    (q.st == ST_RUN && nr_fault) |=> (q.st == ST_LOCK) [*2])
    else $error("non-restartable fault did not lock");

  a_restart_seq: assert property (
    (q.st == ST_WAIT && q.chk_cnt == CHK_LAST && !any_fault && !nr_fault)
      |=> (q.st == ST_RESTART && restart_req_q) ##1 (q.st == ST_RUN && !restart_req_q))
    else $error("restart attempt sequence wrong");

  a_count_inc: assert property (
    (q.st == ST_RUN && any_fault && q.attempted) |=> (q.used == $past(q.used) + 4'h1))
    else $error("restart count not incremented");

  a_quiet_relay: assert property (
    (restarting && !q.relay_sel) |=> !fault_relay_q)
    else $error("fault contact active with relay select zero");

  a_loud_relay: assert property (
    (restarting && q.relay_sel) |=> fault_relay_q)
    else $error("fault contact idle with relay select one");

  a_reset_clear: assert property (
    (q.st == ST_LOCK && freset && !any_fault) |=> (q.st == ST_RUN && q.used == '0))
    else $error("fault reset did not clear count");

  a_limit_lock: assert property (
    (q.st == ST_RUN && any_fault && used_next >= q.limit) |=> (q.st == ST_LOCK && fault_relay_q == 1'b0)
      ##1 fault_relay_q)
    else $error("limit reached without lockout");

endmodule // rlar_protect
`default_nettype wire

// ===== dv/rlar_protect_test.sv
// self-checking bench for reference-loss and auto-restart protection
`timescale 1ns/1ps
`default_nettype none
module rlar_protect_test import rlar_pkg::*;;
  logic mclk, reset, fault_reset_pin, reg_wr, reg_rd;
  logic [REF_W-1:0] ref_in, freq_ref_out_q, refv;
  logic [NUM_FAULTS-1:0] fault_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, rnd, rdv;
  logic drive_stop_q, restart_req_q, fault_relay_q;
  logic [4:0] mfo_q;
  logic [7:0] pct;
  int failures, checks_done;

  // short counts keep the run small
  rlar_protect #(.NUM_MFO(5), .WIN_CYC(20), .CHK_CYC(8), .FF_CYC(200)) rlar_protect_inst (
    .mclk(mclk), .reset(reset), .ref_in(ref_in), .fault_in(fault_in),
    .fault_reset_pin(fault_reset_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .freq_ref_out_q(freq_ref_out_q), .drive_stop_q(drive_stop_q),
    .restart_req_q(restart_req_q), .fault_relay_q(fault_relay_q), .mfo_q(mfo_q));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  // restartable fault bit, drawn from the shared sequence
  function automatic int pick();
    rnd = lfsr_next(rnd);
    return int'(rnd % 14);
  endfunction

  function automatic logic [31:0] cfg_word(input logic resp, input logic rel,
                                           input logic [3:0] lim, input logic [7:0] p);
    return {8'h00, p, 4'h0, lim, 6'h00, rel, resp};
  endfunction

  // integer scaling truncates, same as a percent multiply then divide
  function automatic logic [15:0] exp_freq(input logic [15:0] h, input logic [7:0] p,
                                           input logic run);
    logic [31:0] t;
    t = {16'h0000, h} * {24'h00_0000, p} / 32'h0000_0064;
    return run ? t[15:0] : 16'h0000;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rdv = reg_rdata_q;
  endtask

  task automatic set_fault(input logic [NUM_FAULTS-1:0] v);
    @(posedge mclk);
    fault_in <= v;
    repeat (4) @(negedge mclk);
  endtask

  // pin passes a two-flop sync, so hold it well past that
  task automatic pulse_reset();
    @(posedge mclk);
    fault_reset_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    fault_reset_pin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic check_lock();
    chk(drive_stop_q, 1'b1);
    chk(fault_relay_q, 1'b1);
    rd(REG_STATUS);
    chk({rdv[9], rdv[1:0]}, 3'b110);
  endtask

  // one fault, held across checks, then cleared for one restart
  task automatic fault_cycle(input int bn, input logic rel, input logic [3:0] cnt);
    int n;
    n = 0;
    set_fault(16'h0001 << bn);
    chk(drive_stop_q, 1'b1);
    chk(fault_relay_q, rel);
    chk(mfo_q, 5'b00010);
    rd(REG_STATUS);
    chk(rdv, {22'h00_0000, 1'b0, rel, cnt, 4'h1});
    repeat (12) begin
      @(negedge mclk);
      n += int'(restart_req_q === 1'b1);
    end
    chk(n, 0);
    @(posedge mclk);
    fault_in <= '0;
    repeat (14) begin
      @(negedge mclk);
      n += int'(restart_req_q === 1'b1);
    end
    chk(n, 1);
    chk({drive_stop_q, fault_relay_q, mfo_q}, 7'h00);
  endtask

  // ****************************************************************
  // clock and watchdog
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    report_and_stop();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    ref_in = '0;
    fault_in = '0;
    fault_reset_pin = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    checks_done = 0;
    rnd = 32'h0000_e0c3;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd(REG_CONFIG);
    chk(rdv, 32'h0050_0000);
    rd(REG_STATUS);
    chk(rdv, 32'h0000_0000);
    rd(8'h40);
    chk(rdv, 32'h0000_0000);
    wr(REG_CONFIG, cfg_word(1'b0, 1'b0, 4'hc, 8'h50));
    rd(REG_CONFIG);
    chk(rdv, 32'h0050_0a00);
    wr(REG_MFO_BASE, 32'h0000_000c);
    wr(REG_MFO_BASE + WORD_BYTES, 32'h0000_001e);
    wr(REG_MFO_BASE + 8'h08, 32'h0000_000d);
    rnd = lfsr_next(rnd);
    refv = rnd[15:0] | 16'h0800;
    @(posedge mclk);
    ref_in <= refv;
    repeat (50) @(posedge mclk);
    // near miss, then a real loss per mode
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr_next(rnd);
      pct = (i == 2) ? 8'(rnd % 100 + 1) : 8'h50;
      wr(REG_CONFIG, cfg_word(i != 1, 1'b0, 4'h0, pct));
      @(posedge mclk);
      ref_in <= refv / 5;
      repeat (4) @(negedge mclk);
      chk(mfo_q, 5'b00000);
      chk(freq_ref_out_q, refv / 5);
      @(posedge mclk);
      ref_in <= refv;
      repeat (50) @(posedge mclk);
      ref_in <= refv >> 4;
      repeat (4) @(negedge mclk);
      chk(mfo_q, 5'b00001);
      chk(drive_stop_q, i == 1);
      chk(freq_ref_out_q, exp_freq(refv, pct, i != 1));
      rd(REG_HELD);
      chk(rdv, refv);
      rd(REG_STATUS);
      chk(rdv, 32'h0000_0004);
      @(posedge mclk);
      ref_in <= refv;
      repeat (4) @(negedge mclk);
      chk({mfo_q, drive_stop_q}, 6'h00);
      chk(freq_ref_out_q, refv);
      repeat (50) @(posedge mclk);
    end
    wr(REG_CONFIG, cfg_word(1'b1, 1'b0, 4'h2, 8'h50));
    fault_cycle(pick(), 1'b0, 4'h0);
    wr(REG_CONFIG, cfg_word(1'b1, 1'b1, 4'h2, 8'h50));
    fault_cycle(pick(), 1'b1, 4'h1);
    set_fault(16'h0001 << pick());
    check_lock();
    // reset while the fault persists is ignored
    pulse_reset();
    check_lock();
    @(posedge mclk);
    fault_in <= '0;
    pulse_reset();
    rd(REG_STATUS);
    chk(rdv, 32'h0000_0000);
    // clean period returns the count to its start
    fault_cycle(pick(), 1'b1, 4'h0);
    repeat (210) @(posedge mclk);
    fault_cycle(pick(), 1'b1, 4'h0);
    // a second power-up forgets the attempt history
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(REG_STATUS);
    chk(rdv, 32'h0000_0000);
    wr(REG_CONFIG, cfg_word(1'b1, 1'b1, 4'h2, 8'h50));
    wr(REG_MFO_BASE + WORD_BYTES, 32'h0000_001e);
    // without the clear the leftover attempt would count this fault as one
    fault_cycle(pick(), 1'b1, 4'h0);
    // a fault outside the list locks at once
    rnd = lfsr_next(rnd);
    set_fault(16'h4000 << rnd[0]);
    check_lock();
    @(posedge mclk);
    fault_in <= '0;
    pulse_reset();
    // limit zero allows no attempt at all
    wr(REG_CONFIG, cfg_word(1'b1, 1'b0, 4'h0, 8'h50));
    set_fault(16'h0001 << pick());
    check_lock();
    report_and_stop();
  end
endmodule // rlar_protect_test
`default_nettype wire
